// ===== hdl/wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ==========================================================
// register offsets
`define WDT_OFS_LOAD 8'h00
`define WDT_OFS_VALUE 8'h04
`define WDT_OFS_CTRL 8'h08
`define WDT_OFS_ISTAT 8'h0C
`define WDT_OFS_IMASK 8'h10
`define WDT_OFS_LOCK 8'h14

// ==========================================================
// field positions
`define WDT_CTRL_EN 0
`define WDT_CTRL_RSTEN 1
`define WDT_CTRL_STALL 2
`define WDT_IST_TMO 0
`define WDT_LOCK_BIT 0

// ==========================================================
// reset values and keys
`define WDT_LOAD_RST 32'hFFFFFFFF
`define WDT_IMASK_RST 1'h1
`define WDT_UNLOCK_KEY 32'h5A5AC3C3

`endif

// ===== hdl/wdt_pkg.sv
package wdt_pkg;

    typedef logic [31:0] wdt_word_t;

    typedef enum logic [2:0] {
        WDT_R_LOAD = 3'b000,
        WDT_R_VALUE = 3'b001,
        WDT_R_CTRL = 3'b010,
        WDT_R_ISTAT = 3'b011,
        WDT_R_IMASK = 3'b100,
        WDT_R_LOCK = 3'b101,
        WDT_R_NONE = 3'b111
    } wdt_reg_t;

endpackage

// ===== hdl/wdt_sync.sv
`timescale 1ns/1ns

module wdt_sync
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic din,
    output logic dout
);

    logic meta_r;

    // ==========================================================
    // two-flop synchroniser
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end
        else if (ce)
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule

// ===== hdl/wdt_top.sv
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "wdt_defs.svh"

// Function
// - reload value kept, readable, used at timeout
// - live reload write loads counter at once
// - zero reload write raises interrupt immediately
// - lock blocks load and mask writes, and control writes except the stall bit
// - reset only when reset enable set
// - running state readable by software
// - no stall: count through debug halt
// - stall: hold count while halted
// - unlock lets configuration writes through again
// - counter readable without disturbing it
// - 32-bit down counter, timeout at zero
// - enabling counter also enables interrupt
// - second uncleared timeout asserts system reset
// - clearing interrupt reloads counter
module wdt_top
    import wdt_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic DBG_HALT,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    output logic SYS_RST_REQ
);

    wdt_word_t load_r;
    wdt_word_t cnt_r;
    logic en_r;
    logic rsten_r;
    logic stall_r;
    logic locked_r;
    logic istat_r;
    logic imask_r;
    logic rst_req_r;
    wdt_word_t prdata_r;
    logic halt_s;
    wdt_reg_t sel;
    logic acc;
    logic wr;
    logic rd;
    logic wr_load;
    logic wr_ctrl;
    logic clr_int;
    logic tick;
    logic timeout;
    logic zero_ev;
    logic en_start;

    // ==========================================================
    // debug halt input from pin
    wdt_sync u_halt_sync
    (
        .clk(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .din(DBG_HALT),
        .dout(halt_s)
    );

    // ==========================================================
    // apb decode
    always_comb
    begin
        unique case (PADDR)
            `WDT_OFS_LOAD: sel = WDT_R_LOAD;
            `WDT_OFS_VALUE: sel = WDT_R_VALUE;
            `WDT_OFS_CTRL: sel = WDT_R_CTRL;
            `WDT_OFS_ISTAT: sel = WDT_R_ISTAT;
            `WDT_OFS_IMASK: sel = WDT_R_IMASK;
            `WDT_OFS_LOCK: sel = WDT_R_LOCK;
            default: sel = WDT_R_NONE;
        endcase
    end

    // zero wait states; a low clock enable stretches the access
    assign PREADY = CE;
    assign acc = PSEL & PENABLE & CE;
    assign PSLVERR = PSEL & PENABLE & (sel == WDT_R_NONE);
    assign wr = acc & PWRITE;
    assign rd = acc & ~PWRITE;
    assign wr_load = wr & (sel == WDT_R_LOAD) & ~locked_r;
    assign wr_ctrl = wr & (sel == WDT_R_CTRL);
    assign clr_int = rd & (sel == WDT_R_ISTAT) & istat_r;
    assign en_start = wr_ctrl & ~locked_r & ~en_r
        & PWDATA[`WDT_CTRL_EN];

    // ==========================================================
    // count events
    assign tick = CE & en_r & ~(stall_r & halt_s);
    // a clearing read in the same cycle does not hide the timeout
    assign timeout = tick & (cnt_r == 32'h00000000) & ~wr_load;
    assign zero_ev = wr_load & en_r
        & (PWDATA == 32'h00000000);

    // ==========================================================
    // read data, captured in the setup cycle
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            prdata_r <= 32'h00000000;
        end
        else if (CE & PSEL & ~PENABLE)
        begin
            prdata_r <= 32'h00000000;
            unique case (sel)
                WDT_R_LOAD: prdata_r <= load_r;
                WDT_R_VALUE: prdata_r <= cnt_r;
                WDT_R_CTRL:
                begin
                    prdata_r[`WDT_CTRL_EN] <= en_r;
                    prdata_r[`WDT_CTRL_RSTEN] <= rsten_r;
                    prdata_r[`WDT_CTRL_STALL] <= stall_r;
                end
                WDT_R_ISTAT: prdata_r[`WDT_IST_TMO] <= istat_r;
                WDT_R_IMASK: prdata_r[`WDT_IST_TMO] <= imask_r;
                WDT_R_LOCK: prdata_r[`WDT_LOCK_BIT] <= locked_r;
                WDT_R_NONE: prdata_r <= 32'h00000000;
            endcase
        end
    end

    assign PRDATA = prdata_r;

    // ==========================================================
    // reload value
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            load_r <= `WDT_LOAD_RST;
        end
        else if (wr_load)
        begin
            load_r <= PWDATA;
        end
    end

    // ==========================================================
    // control bits
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            en_r <= 1'b0;
            rsten_r <= 1'b0;
            stall_r <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            stall_r <= PWDATA[`WDT_CTRL_STALL];
            if (~locked_r)
            begin
                // enable is set-only until system reset
                en_r <= en_r | PWDATA[`WDT_CTRL_EN];
                rsten_r <= PWDATA[`WDT_CTRL_RSTEN];
            end
        end
    end

    // ==========================================================
    // lock register
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            locked_r <= 1'b0;
        end
        else if (wr & (sel == WDT_R_LOCK))
        begin
            locked_r <= (PWDATA != `WDT_UNLOCK_KEY);
        end
    end

    // ==========================================================
    // interrupt mask
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            imask_r <= `WDT_IMASK_RST;
        end
        else if (wr & (sel == WDT_R_IMASK) & ~locked_r)
        begin
            imask_r <= PWDATA[`WDT_IST_TMO];
        end
    end

    // ==========================================================
    // down counter
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            cnt_r <= `WDT_LOAD_RST;
        end
        else if (CE)
        begin
            if (wr_load & en_r)
            begin
                cnt_r <= PWDATA;
            end
            else if (en_start | clr_int)
            begin
                cnt_r <= load_r;
            end
            else if (tick)
            begin
                if (cnt_r == 32'h00000000)
                begin
                    cnt_r <= load_r;
                end
                else
                begin
                    cnt_r <= cnt_r - 32'h00000001;
                end
            end
        end
    end

    // ==========================================================
    // sticky timeout status, cleared by reading it
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            istat_r <= 1'b0;
        end
        else if (timeout | zero_ev)
        begin
            istat_r <= 1'b1;
        end
        else if (clr_int)
        begin
            istat_r <= 1'b0;
        end
    end

    assign IRQ = en_r & istat_r & imask_r;

    // ==========================================================
    // system reset request, held until system reset
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            rst_req_r <= 1'b0;
        end
        else if (timeout & istat_r & rsten_r)
        begin
            rst_req_r <= 1'b1;
        end
    end

    assign SYS_RST_REQ = rst_req_r;

    // ==========================================================
    // checks
    a_reload_first: assert property (@(posedge CLK_SYS) disable iff (RST)
        timeout |=> cnt_r == $past(load_r))
        else $error("counter not reloaded at timeout");

    a_live_load: assert property (@(posedge CLK_SYS) disable iff (RST)
        (wr_load & en_r) |=> cnt_r == $past(PWDATA))
        else $error("live reload not loaded");

    a_zero_irq: assert property (@(posedge CLK_SYS) disable iff (RST)
        zero_ev |=> istat_r ##0 (IRQ == imask_r))
        else $error("zero reload raised no interrupt");

    a_lock_ctrl: assert property (@(posedge CLK_SYS) disable iff (RST)
        (locked_r & wr) |=> $stable(load_r) && $stable(rsten_r)
        && $stable(en_r) && $stable(imask_r))
        else $error("locked configuration changed");

    a_rst_enable: assert property (@(posedge CLK_SYS) disable iff (RST)
        $rose(rst_req_r) |-> $past(rsten_r) && $past(istat_r))
        else $error("reset without enable");

    a_count_run: assert property (@(posedge CLK_SYS) disable iff (RST)
        (tick & ~wr_load & ~clr_int & (cnt_r != 32'h00000000))
        |=> cnt_r == $past(cnt_r) - 32'h00000001)
        else $error("counter did not step down");

    a_stall_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
        (stall_r & halt_s & ~wr_load & ~en_start & ~clr_int)
        |=> $stable(cnt_r))
        else $error("count moved while stalled");

    a_unlock_key: assert property (@(posedge CLK_SYS) disable iff (RST)
        (wr & (sel == WDT_R_LOCK) & (PWDATA == `WDT_UNLOCK_KEY))
        |=> !locked_r)
        else $error("unlock key did not unlock");

    a_second_rst: assert property (@(posedge CLK_SYS) disable iff (RST)
        (timeout & istat_r & rsten_r) |=> SYS_RST_REQ)
        else $error("second timeout did not reset");

    a_clear_reload: assert property (@(posedge CLK_SYS) disable iff (RST)
        (clr_int & ~timeout & ~(wr_load & en_r)) |=> !istat_r
        && cnt_r == $past(load_r))
        else $error("interrupt clear did not reload");

    a_set_wins: assert property (@(posedge CLK_SYS) disable iff (RST)
        (timeout & clr_int) |=> istat_r)
        else $error("clearing read beat a timeout");

    a_rst_disabled: assert property (@(posedge CLK_SYS) disable iff (RST)
        (!rsten_r & !rst_req_r) |=> !rst_req_r)
        else $error("reset raised while reset disabled");

    a_ce_freeze: assert property (@(posedge CLK_SYS) disable iff (RST)
        !CE |=> $stable(cnt_r) && $stable(istat_r)
        && $stable(load_r) && $stable(rst_req_r))
        else $error("state moved while clock enable low");

    a_enable_load: assert property (@(posedge CLK_SYS) disable iff (RST)
        en_start |=> en_r && cnt_r == $past(load_r))
        else $error("enable did not start the count");

    a_free_count: assert property (@(posedge CLK_SYS) disable iff (RST)
        (CE & en_r & ~stall_r & ~wr_load & ~clr_int
        & (cnt_r != 32'h00000000))
        |=> cnt_r == $past(cnt_r) - 32'h00000001)
        else $error("count stopped without stall");

    a_run_read: assert property (@(posedge CLK_SYS) disable iff (RST)
        (CE & PSEL & ~PENABLE & (sel == WDT_R_CTRL))
        |=> PRDATA[`WDT_CTRL_EN] == $past(en_r))
        else $error("running state misread");

    a_value_read: assert property (@(posedge CLK_SYS) disable iff (RST)
        (CE & PSEL & ~PENABLE & (sel == WDT_R_VALUE))
        |=> PRDATA == $past(cnt_r))
        else $error("count misread");

endmodule

// ===== test/wdt_top_tb.sv
`timescale 1ns/1ns
`include "wdt_defs.svh"

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    num_errors++; $display("ERROR t=%0t got %h exp %h", $time, g, e); \
    end end

module wdt_top_tb
    import wdt_pkg::*;
;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic CE = 1'b1;
    logic DBG_HALT = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    wdt_word_t PWDATA = 32'h0;
    wdt_word_t PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic IRQ;
    logic SYS_RST_REQ;
    int num_errors = 0;
    int check_count = 0;
    wdt_word_t rd;
    wdt_word_t v1;
    logic err_s;
    int n;

    wdt_top dut
    (
        .CLK_SYS(CLK_SYS),
        .RST(RST),
        .CE(CE),
        .DBG_HALT(DBG_HALT),
        .PSEL(PSEL),
        .PENABLE(PENABLE),
        .PWRITE(PWRITE),
        .PADDR(PADDR),
        .PWDATA(PWDATA),
        .PRDATA(PRDATA),
        .PREADY(PREADY),
        .PSLVERR(PSLVERR),
        .IRQ(IRQ),
        .SYS_RST_REQ(SYS_RST_REQ)
    );

    always #25 CLK_SYS = ~CLK_SYS;

    // ==========================================================
    // bus and helpers
    task automatic apb(input logic wr, input logic [7:0] a,
        input wdt_word_t d);
        int k;
        k = 0;
        @(posedge CLK_SYS);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLK_SYS);
            k++;
        end while (PREADY !== 1'b1 && k < 50);
        if (k >= 50)
        begin
            num_errors++;
            $display("ERROR t=%0t bus never ready", $time);
        end
        rd = PRDATA;
        err_s = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic do_reset;
        RST <= 1'b1;
        repeat (5) @(posedge CLK_SYS);
        RST <= 1'b0;
    endtask

    task automatic print_verdict;
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset_vals;
        do_reset;
        apb(0, `WDT_OFS_LOAD, 0); `CHK(rd, `WDT_LOAD_RST)
        apb(0, `WDT_OFS_VALUE, 0); `CHK(rd, 32'hFFFFFFFF)
        apb(0, `WDT_OFS_CTRL, 0); `CHK(rd[0], 1'b0)
        apb(0, `WDT_OFS_LOCK, 0); `CHK(rd[0], 1'b0)
        apb(0, 8'h18, 0); `CHK(err_s, 1'b1)
        `CHK(IRQ, 1'b0)
    endtask

    task automatic t_timeout;
        do_reset;
        apb(1, `WDT_OFS_LOAD, 32'h14);
        apb(1, `WDT_OFS_CTRL, 32'h3);
        apb(0, `WDT_OFS_CTRL, 0); `CHK(rd[0], 1'b1)
        apb(0, `WDT_OFS_LOAD, 0); `CHK(rd, 32'h14)
        apb(0, `WDT_OFS_VALUE, 0);
        v1 = rd;
        apb(0, `WDT_OFS_VALUE, 0); `CHK(rd < v1, 1'b1)
        for (n = 0; n < 40 && IRQ !== 1'b1; n++) @(posedge CLK_SYS);
        `CHK(IRQ, 1'b1)
        apb(0, `WDT_OFS_ISTAT, 0); `CHK(rd[0], 1'b1)
        @(posedge CLK_SYS);
        `CHK(IRQ, 1'b0)
        apb(0, `WDT_OFS_VALUE, 0); `CHK(rd > 32'hA, 1'b1)
        repeat (8) @(posedge CLK_SYS);
        `CHK(SYS_RST_REQ, 1'b0)
        for (n = 0; n < 40 && IRQ !== 1'b1; n++) @(posedge CLK_SYS);
        `CHK(IRQ, 1'b1)
        `CHK(SYS_RST_REQ, 1'b0)
    endtask

    task automatic t_reload_live;
        do_reset;
        apb(1, `WDT_OFS_LOAD, 32'h3E8);
        apb(1, `WDT_OFS_CTRL, 32'h1);
        apb(1, `WDT_OFS_LOAD, 32'h28);
        apb(0, `WDT_OFS_VALUE, 0);
        `CHK(rd <= 32'h28 && rd >= 32'h23, 1'b1)
        `CHK(IRQ, 1'b0)
        apb(1, `WDT_OFS_LOAD, 32'h0);
        @(posedge CLK_SYS);
        `CHK(IRQ, 1'b1)
    endtask

    task automatic t_lock;
        do_reset;
        apb(1, `WDT_OFS_LOAD, 32'h32);
        apb(1, `WDT_OFS_LOCK, 32'h0);
        apb(0, `WDT_OFS_LOCK, 0); `CHK(rd[0], 1'b1)
        apb(1, `WDT_OFS_LOAD, 32'h4D);
        apb(0, `WDT_OFS_LOAD, 0); `CHK(rd, 32'h32)
        apb(1, `WDT_OFS_CTRL, 32'h3);
        apb(0, `WDT_OFS_CTRL, 0); `CHK(rd[1:0], 2'h0)
        apb(1, `WDT_OFS_IMASK, 32'h0);
        apb(0, `WDT_OFS_IMASK, 0); `CHK(rd[0], 1'b1)
        apb(1, `WDT_OFS_LOCK, `WDT_UNLOCK_KEY);
        apb(0, `WDT_OFS_LOCK, 0); `CHK(rd[0], 1'b0)
        apb(1, `WDT_OFS_LOAD, 32'h4D);
        apb(0, `WDT_OFS_LOAD, 0); `CHK(rd, 32'h4D)
        apb(1, `WDT_OFS_CTRL, 32'h3);
        apb(0, `WDT_OFS_CTRL, 0); `CHK(rd[1:0], 2'h3)
        apb(1, `WDT_OFS_IMASK, 32'h0);
        apb(0, `WDT_OFS_IMASK, 0); `CHK(rd[0], 1'b0)
    endtask

    task automatic t_reset_out;
        do_reset;
        apb(1, `WDT_OFS_LOAD, 32'h4);
        apb(1, `WDT_OFS_CTRL, 32'h1);
        repeat (30) @(posedge CLK_SYS);
        `CHK(IRQ, 1'b1)
        `CHK(SYS_RST_REQ, 1'b0)
        apb(1, `WDT_OFS_IMASK, 32'h0);
        @(posedge CLK_SYS);
        `CHK(IRQ, 1'b0)
        apb(1, `WDT_OFS_IMASK, 32'h1);
        apb(1, `WDT_OFS_CTRL, 32'h3);
        for (n = 0; n < 20 && SYS_RST_REQ !== 1'b1; n++)
            @(posedge CLK_SYS);
        `CHK(SYS_RST_REQ, 1'b1)
    endtask

    task automatic t_freeze;
        do_reset;
        apb(1, `WDT_OFS_LOAD, 32'h1000);
        apb(1, `WDT_OFS_CTRL, 32'h1);
        apb(0, `WDT_OFS_VALUE, 0);
        v1 = rd;
        CE <= 1'b0;
        repeat (10) @(posedge CLK_SYS);
        `CHK(PREADY, 1'b0)
        CE <= 1'b1;
        apb(0, `WDT_OFS_VALUE, 0); `CHK(v1 - rd, 32'h3)
    endtask

    task automatic t_stall;
        do_reset;
        apb(1, `WDT_OFS_LOAD, 32'h10000);
        apb(1, `WDT_OFS_CTRL, 32'h1);
        DBG_HALT <= 1'b1;
        repeat (4) @(posedge CLK_SYS);
        apb(0, `WDT_OFS_VALUE, 0);
        v1 = rd;
        apb(0, `WDT_OFS_VALUE, 0); `CHK(rd < v1, 1'b1)
        apb(1, `WDT_OFS_CTRL, 32'h5);
        repeat (4) @(posedge CLK_SYS);
        apb(0, `WDT_OFS_VALUE, 0);
        v1 = rd;
        apb(0, `WDT_OFS_VALUE, 0); `CHK(rd, v1)
        DBG_HALT <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
        apb(0, `WDT_OFS_VALUE, 0); `CHK(rd < v1, 1'b1)
    endtask

    // ==========================================================
    // main sequence and hang guard
    initial
    begin
        t_reset_vals;
        t_timeout;
        t_reload_live;
        t_lock;
        t_reset_out;
        t_freeze;
        t_stall;
        print_verdict;
    end

    initial
    begin
        repeat (5000) @(posedge CLK_SYS);
        num_errors++;
        $display("ERROR t=%0t run did not finish", $time);
        print_verdict;
    end
endmodule
